// File: hw/ocs_map.svh
// Register offsets, field positions, reset values and timing counts
// for the OTP calibration shifter.
// Assumes a 200 MHz core clock and a byte-addressed Avalon-MM slave port.
//
// Summary of operation
// R1: OTP voltage offset is a 5-bit two's complement offset to the program voltage.
// R2: Final calibration sum saturates: overflow gives 255, underflow gives 0.
// R3: Drive control is pin offset plus OTP offset plus 8-bit operating setting.
// R4: Host keeps pin offset plus OTP offset within five bits, else undefined.
// R5: Three-bit default temperature coefficient loads on power-save exit or refresh.
// R6: Calibration-shift entry allowed with seal bit 0, refused with seal bit 1.
// R7: Programming voltages outside calibration-shift mode leave OTP cells untouched.
// R8: Nine OTP bits, each cell reachable only through its own shift flip-flop.
// R9: Power-save exit or refresh copies all cells into shift register, up to 5 ms.
// R10: Cells are written by shifting nine bits in, then transferring them to cells.
// R11: Shifted values act on the drive voltage at once, no cell write needed.
// R12: In calibration-shift mode each command byte shifts exactly one data bit.
// R13: After leaving calibration-shift mode, normal command decoding resumes fully.
// R14: Host sends nine bits, or a multiple of nine, before leaving the mode.
// R15: Reset clears every shift register bit, the seal bit included.
// R16: Calibration-shift entry is ignored until an OTP refresh has completed.
// R17: Shift order: offset bits 4..0, coefficient bits 2..0, seal bit last.
// R18: A programmed seal bit stays set, blocking any further change.
// R19: Mode bytes are commands; D7 one stays, zero exits; D0 is the data bit.
// R20: With seal set the entry command is silently ignored, mode stays normal.
// R21: Reset always leaves calibration-shift mode.
// R22: Power control during power-save updates control bits but skips refresh.
// R23: Internal refresh-done flag, cleared at reset, qualifies the entry command.
`ifndef OCS_MAP_SVH
`define OCS_MAP_SVH

`define OCS_REG_OP_VOLT       5'h00
`define OCS_REG_STATUS        5'h04
`define OCS_REG_SHIFT         5'h08
`define OCS_REG_DRIVE         5'h0C
`define OCS_REG_TEMP          5'h10

`define OCS_OP_VOLT_RESET     8'h00

`define OCS_ST_CAL_BIT        0
`define OCS_ST_DONE_BIT       1
`define OCS_ST_BUSY_BIT       2
`define OCS_ST_PC_LSB         3
`define OCS_ST_PS_BIT         5

`define OCS_SR_VOFS_MSB       8
`define OCS_SR_VOFS_LSB       4
`define OCS_SR_TC_MSB         3
`define OCS_SR_TC_LSB         1
`define OCS_SR_SEAL_BIT       0
`define OCS_SR_RESET          9'h000
`define OCS_SHIFT_CNT_LSB     12

`define OCS_CMD_ENTER_CAL     8'h82
`define OCS_CMD_PWR_MASK      8'hF9
`define OCS_CMD_PWR_CODE      8'h29
`define OCS_CMD_CONT_BIT      7

`define OCS_DRIVE_MAX         10'sh0FF
`define OCS_DRIVE_MIN         10'sh000

`define OCS_CLK_MHZ           200
`define OCS_REFRESH_TIME_US   5000
`define OCS_REFRESH_CYCLES    (`OCS_REFRESH_TIME_US * `OCS_CLK_MHZ)

`endif

// File: hw/ocs_pkg.sv
// Types shared by the OTP calibration shifter.
// Assumes nothing of its surroundings.
package ocs_pkg;

  typedef enum logic [0:0] {
    OCS_MODE_NORMAL = 1'b0,
    OCS_MODE_CAL    = 1'b1
  } ocs_mode_t;

  typedef logic [8:0] ocs_slices_t;

endpackage

// File: hw/ocs_top.sv
// OTP calibration shifter: nine OTP slices, calibration-shift mode,
// refresh timing and the saturating drive-voltage adder.
// Assumes decoded command bytes arrive as one-cycle strobes synchronous
// to ref_clk_i, and an external OTP macro presents its cell contents.
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "ocs_map.svh"

module ocs_top
  import ocs_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = `OCS_REFRESH_CYCLES,
  parameter int unsigned CNT_W          = $clog2(REFRESH_CYCLES + 1)
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_dc_i,
  input  wire logic [7:0]  cmd_byte_i,
  input  wire logic        power_save_i,
  input  wire logic [4:0]  pin_voltage_offset_i,
  input  wire logic        prog_voltage_i,
  input  wire logic [8:0]  otp_cell_i,
  output logic             otp_prog_en_o,
  output logic      [8:0]  otp_prog_data_o,
  output logic      [4:0]  otp_voltage_offset_o,
  output logic      [2:0]  otp_temp_coeff_default_o,
  output logic             calibration_shift_mode_o,
  output logic      [1:0]  power_ctrl_bits_o,
  output logic      [7:0]  panel_drive_voltage_o,
  output logic             refresh_busy_o,
  output logic             refresh_done_o
);

  localparam logic [CNT_W-1:0] REFRESH_LAST = CNT_W'(REFRESH_CYCLES - 1);

  ocs_mode_t         mode;
  ocs_mode_t         next_mode;
  ocs_slices_t       shift_reg;
  logic [3:0]        shift_cnt;
  logic              refresh_done;
  logic              refresh_busy;
  logic [CNT_W-1:0]  refresh_cnt;
  logic              power_save_q;
  logic [1:0]        power_ctrl_bits;
  logic [7:0]        operating_voltage_setting;
  logic              bus_ack;
  logic [31:0]       bus_rdata;

  logic              cmd_take;
  logic              is_enter_cal;
  logic              is_power_ctrl;
  logic              seal_bit;
  logic              enter_ok;
  logic              shift_strobe;
  logic              ps_exit;
  logic              refresh_start;
  logic              refresh_end;
  logic              bus_req;
  logic              bus_take;
  logic [4:0]        otp_voltage_offset;
  logic signed [9:0] cal_sum;
  logic [7:0]        next_panel_drive;

  // Command decode. Only command-phase bytes matter to this block.
  assign cmd_take      = cmd_valid_i & ~cmd_dc_i;
  assign is_enter_cal  = cmd_byte_i == `OCS_CMD_ENTER_CAL;
  assign is_power_ctrl = (cmd_byte_i & `OCS_CMD_PWR_MASK) == `OCS_CMD_PWR_CODE;
  assign seal_bit      = shift_reg[`OCS_SR_SEAL_BIT];

  // A zeroed seal after reset is not trustworthy until a refresh lands
  assign enter_ok = refresh_done & ~seal_bit; // see R6 see R16 see R23

  assign shift_strobe = cmd_take & (mode == OCS_MODE_CAL); // see R12 see R19

  // Mode state machine
  always_comb begin
    next_mode = mode;
    case (mode)
      OCS_MODE_NORMAL: begin
        // Refused entry is silent: no status, no error
        if (cmd_take && is_enter_cal && enter_ok) begin // see R6 see R20
          next_mode = OCS_MODE_CAL;
        end
      end
      OCS_MODE_CAL: begin
        // Every command byte is data here; D7 low drops back to normal
        if (shift_strobe && !cmd_byte_i[`OCS_CMD_CONT_BIT]) begin // see R13 see R19
          next_mode = OCS_MODE_NORMAL;
        end
        // Seal loaded by a late refresh also closes the mode
        if (refresh_end && otp_cell_i[`OCS_SR_SEAL_BIT]) begin // see R18
          next_mode = OCS_MODE_NORMAL;
        end
      end
      default: begin
        next_mode = OCS_MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode <= OCS_MODE_NORMAL; // see R21
    end else begin
      mode <= next_mode;
    end
  end

  // Power-save tracking and power control bits
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      power_save_q <= 1'b0;
    end else begin
      power_save_q <= power_save_i;
    end
  end

  assign ps_exit = power_save_q & ~power_save_i;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      power_ctrl_bits <= 2'h0;
    end else if (cmd_take && mode == OCS_MODE_NORMAL && is_power_ctrl) begin
      power_ctrl_bits <= cmd_byte_i[2:1]; // see R22
    end
  end

  // Refresh is requested by power-save exit or by the power control
  // command, the latter only outside power-save.
  assign refresh_start = ps_exit | // see R9 see R5
                         (cmd_take && mode == OCS_MODE_NORMAL && is_power_ctrl
                          && !power_save_i); // see R22

  assign refresh_end = refresh_busy & (refresh_cnt == REFRESH_LAST) & ~refresh_start;

  // Fixed worst-case wait; a new request restarts it rather than queueing
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      refresh_busy <= 1'b0;
    end else if (refresh_start) begin
      refresh_busy <= 1'b1;
    end else if (refresh_end) begin
      refresh_busy <= 1'b0;
    end
  end

  // Counter rests at zero while idle, so a restart needs no extra state
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || refresh_start || refresh_end) begin
      refresh_cnt <= '0;
    end else if (refresh_busy) begin
      refresh_cnt <= refresh_cnt + 1'b1; // see R9
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      refresh_done <= 1'b0; // see R23
    end else if (refresh_end) begin
      refresh_done <= 1'b1; // see R16 see R23
    end
  end

  // Shift register: the only path to the cells. New bits enter at the
  // seal position, so after nine strobes the first bit sits at the MSB.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shift_reg <= `OCS_SR_RESET; // see R15
    end else if (refresh_end) begin
      shift_reg <= otp_cell_i; // see R8 see R9 see R5
    end else if (shift_strobe) begin
      shift_reg <= {shift_reg[7:0], cmd_byte_i[0]}; // see R12 see R17 see R10
    end
  end

  // Bit count modulo nine, so software can spot a short transfer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || refresh_end) begin
      shift_cnt <= 4'h0;
    end else if (shift_strobe) begin
      shift_cnt <= (shift_cnt == 4'h8) ? 4'h0 : shift_cnt + 4'h1; // see R14
    end
  end

  // Programming drive to the cells: only in calibration-shift mode
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      otp_prog_en_o <= 1'b0;
    end else begin
      otp_prog_en_o <= prog_voltage_i && mode == OCS_MODE_CAL; // see R7 see R10
    end
  end

  // Data is only acted on while the enable stands
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      otp_prog_data_o <= 9'h000;
    end else begin
      otp_prog_data_o <= shift_reg; // see R10
    end
  end

  // Calibration adder. The shift register feeds it directly, so shifted
  // values act without any cell write.
  assign otp_voltage_offset = shift_reg[`OCS_SR_VOFS_MSB:`OCS_SR_VOFS_LSB]; // see R11

  // Pin and OTP offsets are signed; their overflow is not caught here
  assign cal_sum = $signed({2'b00, operating_voltage_setting}) // see R3
                 + $signed({{5{pin_voltage_offset_i[4]}}, pin_voltage_offset_i})
                 + $signed({{5{otp_voltage_offset[4]}}, otp_voltage_offset}); // see R1

  always_comb begin
    if (cal_sum > `OCS_DRIVE_MAX) begin
      next_panel_drive = 8'hFF; // see R2
    end else if (cal_sum < `OCS_DRIVE_MIN) begin
      next_panel_drive = 8'h00; // see R2
    end else begin
      next_panel_drive = cal_sum[7:0]; // see R3 see R11
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      panel_drive_voltage_o <= 8'h00;
    end else begin
      panel_drive_voltage_o <= next_panel_drive;
    end
  end

  // Registered views of the slices, the mode, the power control bits and the refresh flags
  // Views lag the internal state by one cycle; the status register does not
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      otp_voltage_offset_o <= 5'h00;
    end else begin
      otp_voltage_offset_o <= otp_voltage_offset;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      otp_temp_coeff_default_o <= 3'h0;
    end else begin
      otp_temp_coeff_default_o <= shift_reg[`OCS_SR_TC_MSB:`OCS_SR_TC_LSB]; // see R5
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      calibration_shift_mode_o <= 1'b0;
    end else begin
      calibration_shift_mode_o <= mode == OCS_MODE_CAL;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      power_ctrl_bits_o <= 2'h0;
    end else begin
      power_ctrl_bits_o <= power_ctrl_bits;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      refresh_busy_o <= 1'b0;
    end else begin
      refresh_busy_o <= refresh_busy;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      refresh_done_o <= 1'b0;
    end else begin
      refresh_done_o <= refresh_done;
    end
  end

  // Avalon-MM slave: every access waits exactly one cycle
  assign bus_req           = avs_read_i | avs_write_i;
  assign bus_take          = bus_req & bus_ack;
  assign avs_waitrequest_o = bus_req & ~bus_ack;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      operating_voltage_setting <= `OCS_OP_VOLT_RESET;
    end else if (bus_take && avs_write_i && avs_byteenable_i[0]
                 && avs_address_i == `OCS_REG_OP_VOLT) begin
      operating_voltage_setting <= avs_writedata_i[7:0];
    end
  end

  always_comb begin
    bus_rdata = 32'h0000_0000;
    case (avs_address_i)
      `OCS_REG_OP_VOLT: begin
        bus_rdata[7:0] = operating_voltage_setting;
      end
      `OCS_REG_STATUS: begin
        bus_rdata[`OCS_ST_CAL_BIT]               = mode == OCS_MODE_CAL;
        bus_rdata[`OCS_ST_DONE_BIT]              = refresh_done;
        bus_rdata[`OCS_ST_BUSY_BIT]              = refresh_busy;
        bus_rdata[`OCS_ST_PC_LSB+1:`OCS_ST_PC_LSB] = power_ctrl_bits;
        bus_rdata[`OCS_ST_PS_BIT]                = power_save_i;
      end
      `OCS_REG_SHIFT: begin
        bus_rdata[8:0]                               = shift_reg;
        bus_rdata[`OCS_SHIFT_CNT_LSB+3:`OCS_SHIFT_CNT_LSB] = shift_cnt;
      end
      `OCS_REG_DRIVE: begin
        bus_rdata[7:0] = panel_drive_voltage_o;
      end
      `OCS_REG_TEMP: begin
        bus_rdata[2:0] = shift_reg[`OCS_SR_TC_MSB:`OCS_SR_TC_LSB];
      end
      default: begin
        bus_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data is registered so it stands at the edge where waitrequest is low
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !bus_ack) begin
      avs_readdata_o <= bus_rdata;
    end
  end

endmodule

// File: dv/ocs_host_model.sv
// Host side of the command port: one decoded byte per send call, nine per shift_word call.
// Assumes the bench calls its tasks; one clock shared with the block.
`timescale 1ns/1ps
module ocs_host_model (
  input  wire logic       clk_i,
  output logic            cmd_valid_o,
  output logic            cmd_dc_o,
  output logic      [7:0] cmd_byte_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_dc_o    = 1'b1;
    cmd_byte_o  = 8'h00;
  end
  task automatic send(input logic [7:0] b, input logic dc);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_dc_o    <= dc;
    cmd_byte_o  <= b;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_dc_o    <= ~dc;
    cmd_byte_o  <= ~b; // Idle lines must not look like the last byte
  endtask
  // Whole words only, so no bit lands in the wrong slice
  task automatic shift_word(input logic [8:0] w, input logic stay);
    for (int i = 8; i >= 0; i--) begin
      send({(i > 0) | stay, 6'h00, w[i]}, 1'b0);
    end
  endtask
endmodule

// File: dv/ocs_top_assertions.sv
// Port-level checks for the OTP calibration shifter.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ocs_top_checker (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       cmd_valid_i,
  input wire logic       cmd_dc_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic       power_save_i,
  input wire logic       prog_voltage_i,
  input wire logic [8:0] otp_cell_i,
  input wire logic       otp_prog_en_o,
  input wire logic [8:0] otp_prog_data_o,
  input wire logic [4:0] otp_voltage_offset_o,
  input wire logic [2:0] otp_temp_coeff_default_o,
  input wire logic       calibration_shift_mode_o,
  input wire logic [1:0] power_ctrl_bits_o,
  input wire logic       refresh_busy_o,
  input wire logic       refresh_done_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic cmd;
  logic pwr;
  assign cmd = cmd_valid_i && !cmd_dc_i;
  assign pwr = cmd && ((cmd_byte_i & 8'hF9) == 8'h29);
  property p_reset;
    disable iff (1'b0) rst_i ##1 rst_i |=> !calibration_shift_mode_o
      && otp_prog_data_o == 9'h000 && !refresh_done_o;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left state");
  property p_prog_gate;
    otp_prog_en_o |-> calibration_shift_mode_o && $past(prog_voltage_i);
  endproperty
  a_prog_gate: assert property (p_prog_gate) else $error("program outside mode");
  property p_entry;
    $rose(calibration_shift_mode_o) |-> refresh_done_o && !otp_prog_data_o[0]
      && $past(cmd && cmd_byte_i == 8'h82, 2);
  endproperty
  a_entry: assert property (p_entry) else $error("bad mode entry");
  property p_shift;
    calibration_shift_mode_o && !refresh_busy_o && cmd && !$past(cmd_valid_i) |->
      ##2 otp_prog_data_o == {$past(otp_prog_data_o[7:0]), $past(cmd_byte_i[0], 2)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");
  property p_cont;
    calibration_shift_mode_o && !refresh_busy_o && cmd && !$past(cmd_valid_i) |->
      ##2 calibration_shift_mode_o == $past(cmd_byte_i[7], 2);
  endproperty
  a_cont: assert property (p_cont) else $error("continuation wrong");
  property p_fields;
    otp_voltage_offset_o == otp_prog_data_o[8:4]
      && otp_temp_coeff_default_o == otp_prog_data_o[3:1];
  endproperty
  a_fields: assert property (p_fields) else $error("fields differ");
  property p_psave;
    pwr && power_save_i && !calibration_shift_mode_o && !refresh_busy_o
      && !$past(cmd_valid_i) |-> ##2 !refresh_busy_o
      && power_ctrl_bits_o == $past(cmd_byte_i[2:1], 2);
  endproperty
  a_psave: assert property (p_psave) else $error("power-save refresh");
  property p_start;
    pwr && !power_save_i && !calibration_shift_mode_o && !$past(cmd_valid_i)
      |-> ##2 refresh_busy_o;
  endproperty
  a_start: assert property (p_start) else $error("no refresh");
  property p_done;
    $fell(refresh_busy_o) && !$past(rst_i) |-> refresh_done_o
      && otp_prog_data_o == $past(otp_cell_i, 2);
  endproperty
  a_done: assert property (p_done) else $error("refresh load wrong");
  c_entry: cover property ($rose(calibration_shift_mode_o));
  c_done: cover property ($fell(refresh_busy_o));
  c_prog: cover property (otp_prog_en_o);
endmodule
bind ocs_top ocs_top_checker u_chk (.ref_clk_i, .rst_i, .cmd_valid_i, .cmd_dc_i,
  .cmd_byte_i, .power_save_i, .prog_voltage_i, .otp_cell_i, .otp_prog_en_o,
  .otp_prog_data_o, .otp_voltage_offset_o, .otp_temp_coeff_default_o,
  .calibration_shift_mode_o, .power_ctrl_bits_o, .refresh_busy_o, .refresh_done_o);

// File: dv/otp_calibration_shifter_bench.sv
// Self-checking bench for the OTP calibration shifter.
// Assumes a short refresh count; the bench plays the OTP macro.
`timescale 1ns/1ps
`include "ocs_map.svh"
module otp_calibration_shifter_bench;
  logic        ref_clk_i = 1'b0;
  logic        rst_i, avs_read_i, avs_write_i, power_save_i, prog_voltage_i;
  logic [4:0]  avs_address_i, pin_voltage_offset_i, otp_voltage_offset_o;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i;
  logic        avs_waitrequest_o, cmd_valid_i, cmd_dc_i, otp_prog_en_o;
  logic [7:0]  cmd_byte_i, panel_drive_voltage_o;
  logic [8:0]  otp_cell_i, otp_prog_data_o;
  logic [2:0]  otp_temp_coeff_default_o;
  logic        calibration_shift_mode_o, refresh_busy_o, refresh_done_o;
  logic [1:0]  power_ctrl_bits_o;
  int          mismatches = 0;
  int          total_checks = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  ocs_top #(.REFRESH_CYCLES(16)) u_dut (.ref_clk_i, .rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .cmd_valid_i, .cmd_dc_i, .cmd_byte_i, .power_save_i,
    .pin_voltage_offset_i, .prog_voltage_i, .otp_cell_i, .otp_prog_en_o,
    .otp_prog_data_o, .otp_voltage_offset_o, .otp_temp_coeff_default_o,
    .calibration_shift_mode_o, .power_ctrl_bits_o, .panel_drive_voltage_o,
    .refresh_busy_o, .refresh_done_o);
  ocs_host_model u_host (.clk_i(ref_clk_i), .cmd_valid_o(cmd_valid_i),
    .cmd_dc_o(cmd_dc_i), .cmd_byte_o(cmd_byte_i));
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // Refresh starts two edges after its cause
  task automatic wait_refresh();
    int n;
    repeat (3) @(posedge ref_clk_i);
    for (n = 0; n < 200 && refresh_busy_o !== 1'b0; n++) @(posedge ref_clk_i);
    if (n >= 200) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  function automatic logic [31:0] sat(input int s);
    return (s > 255) ? 32'hFF : (s < 0) ? 32'h0 : 32'(s);
  endfunction
  task automatic drv(input logic [7:0] op, input logic [4:0] pin, input int e);
    @(posedge ref_clk_i);
    pin_voltage_offset_i <= pin;
    wr(`OCS_REG_OP_VOLT, {24'h0, op});
    rc(`OCS_REG_DRIVE, 32'hFF, sat(e));
    check(32'(panel_drive_voltage_o), sat(e));
  endtask
  task automatic t_reset();
    rc(`OCS_REG_SHIFT, 32'hF1FF, 32'h0);
    rc(`OCS_REG_STATUS, 32'h3F, 32'h0);
    wr(`OCS_REG_SHIFT, 32'h1FF);
    rc(`OCS_REG_SHIFT, 32'h1FF, 32'h0);
    wr(5'h14, 32'hFF);
    rc(5'h14, 32'hFFFFFFFF, 32'h0);
    u_host.send(8'h82, 1'b0);
    rc(`OCS_REG_STATUS, 32'h1, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_refresh();
    @(posedge ref_clk_i);
    power_save_i <= 1'b1;
    u_host.send(8'h2F, 1'b0);
    rc(`OCS_REG_STATUS, 32'h3F, 32'h38);
    check(32'(power_ctrl_bits_o), 32'h3);
    power_save_i <= 1'b0;
    wait_refresh();
    rc(`OCS_REG_SHIFT, 32'h1FF, 32'h1C4);
    rc(`OCS_REG_TEMP, 32'h7, 32'h2);
    check(32'(otp_voltage_offset_o), 32'h1C);
    check(32'(refresh_done_o), 32'h1);
    $display("refresh test done");
  endtask
  task automatic t_adder();
    drv(8'h80, 5'h03, 128 + 3 - 4);
    drv(8'h01, 5'h00, 1 - 4);
    drv(8'hFF, 5'h0F, 255 + 15 - 4);
    drv(8'h10, 5'h1E, 16 - 2 - 4);
    $display("adder test done");
  endtask
  task automatic t_cal();
    u_host.send(8'h82, 1'b1);
    rc(`OCS_REG_STATUS, 32'h1, 32'h0);
    u_host.send(8'h82, 1'b0);
    rc(`OCS_REG_STATUS, 32'h1, 32'h1);
    check(32'(calibration_shift_mode_o), 32'h1);
    u_host.shift_word(9'h0AA, 1'b1);
    rc(`OCS_REG_SHIFT, 32'hF1FF, 32'h0AA);
    check(32'(otp_temp_coeff_default_o), 32'h5);
    drv(8'h10, 5'h00, 16 + 10);
    prog_voltage_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check({22'h0, otp_prog_en_o, otp_prog_data_o}, 32'h2AA);
    prog_voltage_i <= 1'b0;
    u_host.shift_word(9'h0AA, 1'b0);
    rc(`OCS_REG_STATUS, 32'h1, 32'h0);
    check(32'(calibration_shift_mode_o), 32'h0);
    prog_voltage_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    check(32'(otp_prog_en_o), 32'h0);
    prog_voltage_i <= 1'b0;
    u_host.send(8'h29, 1'b0);
    wait_refresh();
    rc(`OCS_REG_SHIFT, 32'h1FF, 32'h1C4);
    u_host.send(8'h82, 1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rc(`OCS_REG_STATUS, 32'h7, 32'h0);
    rc(`OCS_REG_SHIFT, 32'h1FF, 32'h0);
    $display("calibration test done");
  endtask
  task automatic t_seal();
    otp_cell_i <= 9'h1C5;
    u_host.send(8'h29, 1'b0);
    wait_refresh();
    u_host.send(8'h82, 1'b0);
    rc(`OCS_REG_STATUS, 32'h1, 32'h0);
    rc(`OCS_REG_SHIFT, 32'h1, 32'h1);
    $display("seal test done");
  endtask
  initial begin
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    power_save_i = 1'b0;
    prog_voltage_i = 1'b0;
    pin_voltage_offset_i = 5'h00;
    otp_cell_i = 9'h1C4;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_refresh();
    t_adder();
    t_cal();
    t_seal();
    report_and_stop();
  end
endmodule
